// [opt_pkg.sv]
// Constants shared by the one-shot / PWM timer channel.
// Assumes a 50 MHz system clock and a 32-bit Avalon-MM register bus.
`default_nettype none

package opt_pkg;

    // Register byte addresses.
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_VALUE  = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // Control register field positions.
    localparam int CTRL_START  = 0;
    localparam int CTRL_FIRE   = 1;
    localparam int CTRL_PWM    = 2;
    localparam int CTRL_PWM8   = 3;
    localparam int CTRL_SRC_LO = 4;
    localparam int CTRL_OVF_EN = 6;
    localparam int CTRL_IN_TRG = 8;
    localparam int CTRL_OUT_PL = 9;
    localparam int CTRL_GPIO   = 10;
    localparam int CTRL_FALL   = 11;
    localparam int CTRL_W      = 12;

    // Status register field positions.
    localparam int STAT_RUN = 0;
    localparam int STAT_OUT = 1;
    localparam int STAT_PIN = 2;

    // Values after reset.
    localparam logic [11:0] CTRL_RST  = 12'h000;
    localparam logic [15:0] VALUE_RST = 16'h0000;

    // PWM cycle lengths, in steps.
    localparam logic [15:0] PWM16_CYCLE = 16'hFFFF;
    localparam logic [15:0] PWM8_CYCLE  = 16'h00FF;

    // Count source dividers.
    localparam logic [4:0] DIV8_LAST  = 5'h07;
    localparam logic [4:0] DIV32_LAST = 5'h1F;

    // Count source selection codes.
    typedef enum logic [1:0] {
        OPT_SRC_DIV1   = 2'h0,
        OPT_SRC_DIV8   = 2'h1,
        OPT_SRC_DIV32  = 2'h2,
        OPT_SRC_SUB32  = 2'h3
    } opt_src_t;

    // Channel states.
    typedef enum logic [1:0] {
        OPT_ST_STOP,
        OPT_ST_WAIT,
        OPT_ST_RUN
    } opt_state_t;

endpackage : opt_pkg

`default_nettype wire

// [opt_tick_if.sv]
// Carries count source selection and the resulting tick.
// Assumes one clock shared by the timer core and its prescaler.
`timescale 1ns/10ps
`default_nettype none

interface opt_tick_if;
    opt_pkg::opt_src_t sel;
    logic              sub_level;
    logic              tick;
    modport pre  (input sel, input sub_level, output tick);
    modport core (output sel, output sub_level, input tick);
endinterface : opt_tick_if

`default_nettype wire

// [opt_sync.sv]
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to clock.
`timescale 1ns/10ps
`default_nettype none

module opt_sync (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic d,
    output var  logic q
);
    logic meta;

    // The first flop feeds only the second one.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : opt_sync

`default_nettype wire

// [opt_prescaler.sv]
// Count source generator: one tick pulse per selected source period.
// Assumes sub_level is already synchronised to clock.
`timescale 1ns/10ps
`default_nettype none

module opt_prescaler (
    input  wire logic   clock,
    input  wire logic   rst_b,
    opt_tick_if.pre     src
);
    logic [4:0] div;
    logic [4:0] sub_div;
    logic       sub_q;

    // Free-running divider for the internal clock sources.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) div <= 5'h00;
        else        div <= div + 5'h01;
    end

    // Subclock rising edges are counted by 32.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sub_q   <= 1'b0;
            sub_div <= 5'h00;
        end else begin
            sub_q <= src.sub_level;
            if (src.sub_level && !sub_q) sub_div <= sub_div + 5'h01;
        end
    end

    // Tick is one clock wide; subclock tick fires on the 32nd edge.
    always_comb begin
        case (src.sel)
            opt_pkg::OPT_SRC_DIV1:  src.tick = 1'b1;
            opt_pkg::OPT_SRC_DIV8:  src.tick = (div[2:0] == opt_pkg::DIV8_LAST[2:0]);
            opt_pkg::OPT_SRC_DIV32: src.tick = (div == opt_pkg::DIV32_LAST);
            opt_pkg::OPT_SRC_SUB32: src.tick = src.sub_level && !sub_q
                                               && (sub_div == opt_pkg::DIV32_LAST);
            default:                src.tick = 1'b0;
        endcase
    end
endmodule : opt_prescaler

`default_nettype wire

// [oneshot_pwm_timer.sv]
// Timer channel with one-shot and PWM modes behind an Avalon-MM slave.
// Assumes pins are asynchronous and timer_ovf_in is a same-clock pulse.
// Function
// RULE1 - One-shot: after trigger, decrement on each count tick until zero.
// RULE2 - One-shot: at zero, reload counter and halt until next start.
// RULE3 - One-shot: trigger while running reloads and restarts the countdown.
// RULE4 - One-shot starts on pin edge, trigger timer overflow, or fire flag.
// RULE5 - Clearing the start flag stops counting in both modes.
// RULE6 - One-shot: interrupt request when countdown reaches zero.
// RULE7 - Input pin is GPIO or trigger; output pin is GPIO or pulse.
// RULE8 - Reading the value register returns an undefined value.
// RULE9 - Value write while stopped loads reload register and counter.
// RULE10 - Value write while running loads only the reload register.
// RULE11 - PWM counts down as 16-bit or prescaled 8-bit modulator.
// RULE12 - PWM reloads at each output rising edge and keeps counting.
// RULE13 - PWM ignores triggers once counting.
// RULE14 - PWM16: high n periods, cycle 65535 periods.
// RULE15 - PWM8: high n*(m+1), cycle 255*(m+1); m low byte.
// RULE16 - PWM starts on pin edge, trigger timer overflow, or start flag.
// RULE17 - One-shot stop mid-count: reload, output low, interrupt request.
// RULE18 - PWM stop: high output goes low with interrupt; low output unchanged.
// RULE19 - One-shot output is aligned to count ticks, up to one period late.
// RULE20 - Trigger source spaces retriggers by more than one count period.
// RULE21 - Count source selects among three prescaled clocks and divided subclock.
// RULE22 - PWM: interrupt request on every output falling edge.
// RULE23 - One-shot: output high while counting, low otherwise.
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module oneshot_pwm_timer (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        trigger_input_pin,
    input  wire logic        subclock_pin,
    input  wire logic        timer_ovf_in,
    output var  logic        pulse_output_pin,
    output var  logic        irq_req
);
    opt_tick_if src ();

    logic [11:0]            ctrl;
    logic [15:0]            reload;
    logic [15:0]            cnt;
    logic [15:0]            per;
    logic [7:0]             pre;
    logic                   out_q;
    logic                   pend;
    logic                   ack;
    logic                   pin_s;
    logic                   pin_q;
    opt_pkg::opt_state_t    state;

    logic                   wr_go;
    logic                   wr_ctrl;
    logic                   wr_val;
    logic [15:0]            next_val;
    logic                   fire;
    logic                   stop_evt;
    logic                   pin_edge;
    logic                   trig;
    logic                   pwm;
    logic                   pwm8;
    logic                   step;
    logic [15:0]            cycle;
    logic [15:0]            load_n;

    // Both pin inputs pass two flops before any logic reads them.
    opt_sync u_sync_trg (
        .clock (clock),
        .rst_b (rst_b),
        .d     (trigger_input_pin),
        .q     (pin_s)
    );
    opt_sync u_sync_sub (
        .clock (clock),
        .rst_b (rst_b),
        .d     (subclock_pin),
        .q     (src.sub_level)
    );

    // Count source generation.
    opt_prescaler u_pre (
        .clock (clock),
        .rst_b (rst_b),
        .src   (src.pre)
    );
    assign src.sel = opt_pkg::opt_src_t'(ctrl[opt_pkg::CTRL_SRC_LO +: 2]); // see RULE21

    // One wait state: the request is taken at the edge where ack is high.
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign wr_go   = avs_write && ack;
    assign wr_ctrl = wr_go && avs_address == opt_pkg::ADDR_CTRL;
    assign wr_val  = wr_go && avs_address == opt_pkg::ADDR_VALUE;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) ack <= 1'b0;
        else        ack <= (avs_read || avs_write) && !ack;
    end

    // Byte lanes merge into the current reload value.
    always_comb begin
        next_val = reload;
        if (avs_byteenable[0]) next_val[7:0]  = avs_writedata[7:0];
        if (avs_byteenable[1]) next_val[15:8] = avs_writedata[15:8];
    end

    // Control register; the fire bit is a write-only strobe.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= opt_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            if (avs_byteenable[0]) ctrl[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1]) ctrl[11:8] <= avs_writedata[11:8];
            if (avs_byteenable[0]) ctrl[opt_pkg::CTRL_FIRE] <= 1'b0;
        end
    end

    assign pwm  = ctrl[opt_pkg::CTRL_PWM];
    assign pwm8 = ctrl[opt_pkg::CTRL_PWM8];
    assign fire = wr_ctrl && avs_byteenable[0]
                  && avs_writedata[opt_pkg::CTRL_FIRE];
    // A stop is a write that clears a set start flag.
    assign stop_evt = wr_ctrl && avs_byteenable[0] && ctrl[opt_pkg::CTRL_START]
                      && !avs_writedata[opt_pkg::CTRL_START];

    // Trigger pin edge detect on the synchronised level only.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) pin_q <= 1'b0;
        else        pin_q <= pin_s;
    end
    assign pin_edge = ctrl[opt_pkg::CTRL_FALL] ? (pin_q && !pin_s) : (!pin_q && pin_s);

    // The pin acts as trigger only when assigned to the timer.
    assign trig = (ctrl[opt_pkg::CTRL_IN_TRG] && pin_edge)        // see RULE7
                  || (ctrl[opt_pkg::CTRL_OVF_EN] && timer_ovf_in)  // see RULE4
                  || (!pwm && fire);                               // see RULE4

    // In 8-bit PWM the low byte prescales each step.
    assign step   = src.tick && (!pwm || !pwm8 || pre == 8'h00);    // see RULE15
    assign cycle  = pwm8 ? opt_pkg::PWM8_CYCLE : opt_pkg::PWM16_CYCLE;
    assign load_n = pwm8 ? {8'h00, reload[15:8]} : reload;          // see RULE11

    // Reload register follows every value write.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)      reload <= opt_pkg::VALUE_RST;
        else if (wr_val) reload <= next_val;                        // see RULE10
    end

    // Channel state, counter and output level.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state   <= opt_pkg::OPT_ST_STOP;
            cnt     <= opt_pkg::VALUE_RST;
            per     <= 16'h0000;
            pre     <= 8'h00;
            out_q   <= 1'b0;
            pend    <= 1'b0;
            irq_req <= 1'b0;
        end else begin
            irq_req <= 1'b0;
            if (stop_evt) begin
                state <= opt_pkg::OPT_ST_STOP;                      // see RULE5
                pend  <= 1'b0;
                out_q <= 1'b0;                                       // see RULE18
                if (!pwm) begin
                    cnt     <= reload;                               // see RULE17
                    irq_req <= (state == opt_pkg::OPT_ST_RUN);       // see RULE17
                end else begin
                    irq_req <= out_q;                                // see RULE18
                end
            end else begin
                case (state)
                    opt_pkg::OPT_ST_STOP: begin
                        if (wr_val) cnt <= next_val;                 // see RULE9
                        if (wr_ctrl && avs_byteenable[0] && avs_writedata[opt_pkg::CTRL_START]) begin
                            state <= opt_pkg::OPT_ST_WAIT;
                            // A fire bit written together with the start bit is kept, not lost.
                            if (fire && !avs_writedata[opt_pkg::CTRL_PWM]) pend <= 1'b1;  // see RULE4
                        end
                    end
                    opt_pkg::OPT_ST_WAIT: begin
                        if (wr_val) cnt <= next_val;                 // see RULE9
                        if (pwm) begin
                            // Without a trigger source the start flag alone starts.
                            if (trig || !(ctrl[opt_pkg::CTRL_IN_TRG] || ctrl[opt_pkg::CTRL_OVF_EN])) begin
                                state <= opt_pkg::OPT_ST_RUN;        // see RULE16
                                per   <= 16'h0000;
                                pre   <= 8'h00;
                            end
                        end else begin
                            // Triggers wait for the next tick so the pulse is tick aligned.
                            if (trig) pend <= 1'b1;                  // see RULE19
                            if (src.tick && (pend || trig)) begin
                                pend <= 1'b0;
                                // A value written at the starting edge is the one counted.
                                cnt  <= wr_val ? next_val : reload;  // see RULE9
                                if ((wr_val ? next_val : reload) == 16'h0000) begin
                                    irq_req <= 1'b1;                 // see RULE6
                                end else begin
                                    out_q <= 1'b1;                   // see RULE23
                                    state <= opt_pkg::OPT_ST_RUN;
                                end
                            end
                        end
                    end
                    opt_pkg::OPT_ST_RUN: begin
                        if (!pwm) begin
                            if (trig) pend <= 1'b1;                  // see RULE20
                            if (src.tick) begin
                                if (pend || trig) begin
                                    pend <= 1'b0;
                                    cnt  <= reload;                  // see RULE3
                                end else if (cnt <= 16'h0001) begin
                                    cnt     <= reload;               // see RULE2
                                    out_q   <= 1'b0;                 // see RULE23
                                    irq_req <= 1'b1;                 // see RULE6
                                    state   <= opt_pkg::OPT_ST_WAIT; // see RULE2
                                end else begin
                                    cnt <= cnt - 16'h0001;           // see RULE1
                                end
                            end
                        end else begin
                            // Triggers are not looked at here at all.
                            if (src.tick) begin                      // see RULE13
                                pre <= (pre == 8'h00) ? reload[7:0] : pre - 8'h01;
                            end
                            if (step) begin
                                per <= (per >= cycle - 16'h0001) ? 16'h0000 : per + 16'h0001; // see RULE14
                                if (per == 16'h0000) begin
                                    cnt   <= load_n;                 // see RULE12
                                    out_q <= (load_n != 16'h0000);   // see RULE12
                                end else if (cnt != 16'h0000) begin
                                    cnt <= cnt - 16'h0001;           // see RULE11
                                    if (cnt == 16'h0001) begin
                                        out_q   <= 1'b0;             // see RULE14
                                        irq_req <= 1'b1;             // see RULE22
                                    end
                                end
                            end
                        end
                    end
                    default: state <= opt_pkg::OPT_ST_STOP;
                endcase
            end
        end
    end

    // Output pin: timer pulse or a plain GPIO level.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) pulse_output_pin <= 1'b0;
        else        pulse_output_pin <= ctrl[opt_pkg::CTRL_OUT_PL] ? out_q   // see RULE7
                                        : ctrl[opt_pkg::CTRL_GPIO];
    end

    // Read data is captured while waitrequest is high, stable at the answer.
    // The value register reads zero: the live count is not offered.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            case (avs_address)
                opt_pkg::ADDR_CTRL:   avs_readdata <= {20'h00000, ctrl};
                opt_pkg::ADDR_VALUE:  avs_readdata <= 32'h0000_0000;  // see RULE8
                opt_pkg::ADDR_STATUS: avs_readdata <= {29'h0, pin_s, out_q,
                                                       state == opt_pkg::OPT_ST_RUN};
                default:              avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    logic os_run;
    assign os_run = !pwm && state == opt_pkg::OPT_ST_RUN;

    // One-shot countdown, end, retrigger and start.
    AST_OS_DECR: assert property (os_run && src.tick && !pend && !trig && !stop_evt  // see RULE1
        && cnt > 16'h0001 |=> cnt == $past(cnt) - 16'h0001)
        else $error("one-shot counter did not decrement");

    AST_OS_END: assert property (os_run && src.tick && !pend && !trig && !stop_evt   // see RULE2
        && cnt == 16'h0001 |=> state == opt_pkg::OPT_ST_WAIT && !out_q && irq_req)
        else $error("one-shot end did not halt and request");

    AST_OS_RETRIG: assert property (os_run && src.tick && pend && !stop_evt && !wr_val  // see RULE3
        |=> cnt == reload && state == opt_pkg::OPT_ST_RUN)
        else $error("retrigger did not reload");

    AST_OS_FIRE_START: assert property (state == opt_pkg::OPT_ST_STOP && fire  // see RULE4
        && avs_writedata[opt_pkg::CTRL_START] && !avs_writedata[opt_pkg::CTRL_PWM] |=> pend)
        else $error("fire with start was lost");

    AST_OS_START: assert property (!pwm && state == opt_pkg::OPT_ST_WAIT && src.tick  // see RULE19
        && (pend || trig) && !stop_evt && !wr_val && reload != 16'h0000
        |=> state == opt_pkg::OPT_ST_RUN && out_q)
        else $error("one-shot did not start on tick");

    // Stop and register write behaviour in both modes.
    AST_STOP: assert property (stop_evt |=> state == opt_pkg::OPT_ST_STOP ##1   // see RULE5
        state != opt_pkg::OPT_ST_RUN)
        else $error("start flag clear did not stop");

    AST_WR_STOPPED: assert property (wr_val && state != opt_pkg::OPT_ST_RUN    // see RULE9
        && !stop_evt |=> cnt == reload)
        else $error("stopped write did not load counter");

    AST_WR_RUN: assert property (wr_val && state == opt_pkg::OPT_ST_RUN        // see RULE10
        && !src.tick |=> cnt == $past(cnt))
        else $error("running write changed counter");

    // Modulator reload, wrap, off-tick stability and falling edge request; stop in each mode and one-shot idle output.
    AST_PWM_IGNORE: assert property (pwm && state == opt_pkg::OPT_ST_RUN       // see RULE13
        && !src.tick && !stop_evt |=> $stable(cnt) && $stable(out_q))
        else $error("pwm reacted off-tick");

    AST_PWM_RELOAD: assert property (pwm && state == opt_pkg::OPT_ST_RUN && step  // see RULE12
        && per == 16'h0000 && !stop_evt |=> cnt == $past(load_n) && out_q == ($past(load_n) != 16'h0000))
        else $error("pwm did not reload at rise");

    AST_PWM_WRAP: assert property (pwm && !pwm8 && state == opt_pkg::OPT_ST_RUN && step && !stop_evt  // see RULE14
        && per == opt_pkg::PWM16_CYCLE - 16'h0001 |=> per == 16'h0000)
        else $error("pwm period did not wrap");

    AST_PWM_FALL: assert property (pwm && $fell(out_q) |-> irq_req)          // see RULE22
        else $error("pwm fall without request");

    AST_OS_STOP: assert property (os_run && stop_evt                          // see RULE17
        |=> !out_q && irq_req && cnt == $past(reload))
        else $error("one-shot stop misbehaved");

    AST_PWM_STOP_LOW: assert property (pwm && stop_evt && !out_q |=> !irq_req)  // see RULE18
        else $error("pwm stop while low raised request");

    AST_OS_OUT: assert property (!pwm && state != opt_pkg::OPT_ST_RUN |-> !out_q)  // see RULE23
        else $error("one-shot output high while idle");

    COV_OS_DONE: cover property (os_run ##1 irq_req);
    COV_PWM_FALL: cover property (pwm && $fell(out_q));
    COV_RETRIG: cover property (os_run && pend && src.tick);
    COV_PWM_STOP: cover property (pwm && stop_evt && out_q);
    COV_PWM8_STEP: cover property (pwm && pwm8 && step && per == 16'h0000);

endmodule : oneshot_pwm_timer

`default_nettype wire

// [opt_partner.sv]
// Far side model: trigger source on the input pin and a load on the pulse pin.
// Assumes it shares the timer's clock; the load only measures, it never drives.
`timescale 1ns/10ps
`default_nettype none

module opt_partner (
    input  wire logic        clock,
    input  wire logic        trig_req,
    input  wire logic        pulse_output_pin,
    output var  logic        trigger_input_pin,
    output var  logic [31:0] high_len,
    output var  logic [31:0] period,
    output var  logic [31:0] falls
);
    logic [31:0] run;
    logic [31:0] since;
    logic        last;

    initial begin
        {run, since, last, high_len, period, falls} = '0;
    end

    // The pin follows requests that the bench spaces far apart.
    always @(posedge clock) trigger_input_pin <= trig_req;

    // High time, rise-to-rise period and a count of falling edges.
    always @(posedge clock) begin
        last  <= pulse_output_pin;
        since <= since + 1;
        run   <= pulse_output_pin ? run + 1 : 0;
        if (pulse_output_pin && !last) begin
            period <= since;
            since  <= 1;
        end
        if (!pulse_output_pin && last) begin
            high_len <= run;
            falls    <= falls + 1;
        end
    end
endmodule : opt_partner

`default_nettype wire

// [testbench.sv]
// Self-checking bench for the one-shot and PWM timer channel.
// Assumes a 50 MHz clock; overflow and subclock inputs are held idle.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        trig_req = 1'b0;
    logic        trigger_input_pin;
    logic        pulse_output_pin;
    logic        irq_req;
    logic [31:0] high_len, period, falls, rd;
    int          fail_count = 0;
    int          tests_run = 0;
    int          irq_count = 0;
    int          i0;

    always #10 clock = ~clock;

    // Interrupt pulses are counted so the fire, stop and PWM8 scenarios can check how many came.
    always @(posedge clock) if (irq_req === 1'b1) irq_count <= irq_count + 1;

    oneshot_pwm_timer uut (.clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trigger_input_pin(trigger_input_pin),
        .subclock_pin(1'b0), .timer_ovf_in(1'b0), .pulse_output_pin(pulse_output_pin), .irq_req(irq_req));

    opt_partner part (.clock(clock), .trig_req(trig_req), .pulse_output_pin(pulse_output_pin),
        .trigger_input_pin(trigger_input_pin), .high_len(high_len), .period(period), .falls(falls));

    task tally_and_finish;
        $display("Checks %0d, errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    // One Avalon transfer; the request stands until waitrequest is seen low.
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            tally_and_finish();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : bus

    // Bounded wait for the next falling edge of the pulse pin.
    task wait_fall(input int bound);
        int n;
        logic [31:0] f;
        f = falls;
        n = 0;
        while (falls === f && n < bound) begin
            @(posedge clock);
            n++;
        end
        if (n >= bound) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : wait_fall

    task s_regs;
        bus(0, 4'h0, 0); chk("ctrl", 32'h0, rd);
        bus(0, 4'h4, 0); chk("value", 32'h0, rd);
        bus(0, 4'hC, 0); chk("unmapped", 32'h0, rd);
    endtask : s_regs

    task s_fire(input logic [31:0] src, input int mul);
        bus(1, 4'h4, 32'h5);
        bus(1, 4'h0, 32'h201 | (src << 4));
        i0 = irq_count;
        bus(1, 4'h0, 32'h203 | (src << 4));
        wait_fall(500); chk("high", 5 * mul, high_len);
        bus(0, 4'h8, 0); chk("status", 32'h0, rd);
        chk("irq", i0 + 1, irq_count);
    endtask : s_fire

    task s_pin;
        bus(1, 4'h0, 32'h301);
        trig_req <= 1'b1;
        repeat (2) @(posedge clock);
        trig_req <= 1'b0;
        wait_fall(100); chk("pin high", 32'h5, high_len);
    endtask : s_pin

    task s_stop;
        bus(1, 4'h0, 32'h200);
        bus(1, 4'h4, 32'hC8);
        bus(1, 4'h0, 32'h203);
        repeat (20) @(posedge clock);
        i0 = irq_count;
        bus(1, 4'h0, 32'h200);
        bus(0, 4'h8, 0); chk("stop status", 32'h0, rd);
        chk("stop irq", i0 + 1, irq_count);
    endtask : s_stop

    task s_pwm8;
        int n;
        bus(1, 4'h4, 32'h0201);
        bus(1, 4'h0, 32'h20D);
        wait_fall(600);
        i0 = irq_count;
        wait_fall(600); chk("p8 high", 32'h4, high_len);
        chk("p8 period", 32'd510, period);
        bus(1, 4'h4, 32'h0301);
        wait_fall(600);
        wait_fall(600); chk("p8 new high", 32'h6, high_len);
        chk("p8 irq", i0 + 3, irq_count);
        n = 0;
        while (pulse_output_pin !== 1'b1 && n < 600) begin
            @(posedge clock);
            n++;
        end
        if (n >= 600) begin
            fail_count++;
            tally_and_finish();
        end
        i0 = irq_count;
        bus(1, 4'h0, 32'h200);
        bus(0, 4'h8, 0); chk("p8 stop", 32'h0, rd);
        chk("p8 stop irq", i0 + 1, irq_count);
    endtask : s_pwm8

    task s_pwm16;
        bus(1, 4'h4, 32'h3);
        bus(1, 4'h0, 32'h205);
        wait_fall(100); chk("p16 high", 32'h3, high_len);
        wait_fall(70000); chk("p16 period", 32'd65535, period);
        bus(1, 4'h0, 32'h200);
    endtask : s_pwm16

    task s_gpio;
        bus(1, 4'h0, 32'h400);
        @(posedge clock);
        chk("gpio out", 32'h1, {31'h0, pulse_output_pin});
        trig_req <= 1'b1;
        repeat (4) @(posedge clock);
        bus(0, 4'h8, 0); chk("gpio in", 32'h4, rd);
        trig_req <= 1'b0;
    endtask : s_gpio

    // Main sequence; reset is held for 16 cycles first.
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        s_regs();
        s_fire(0, 1);
        s_fire(1, 8);
        s_pin();
        s_stop();
        s_pwm8();
        s_pwm16();
        s_gpio();
        tally_and_finish();
    end
endmodule : testbench

`default_nettype wire
